// ==== include/psd_defs.vh ====
`ifndef PSD_DEFS_VH
`define PSD_DEFS_VH
`define PSD_LANES 4
`define PSD_LANE_W 9
`define PSD_DATA_W 36
`define PSD_ADDR_W 18
`define PSD_BURST_W 2
`define PSD_ONE_2 2'h1
`define PSD_ZERO_2 2'h0
`define PSD_SLEEP_CYC 2
`define PSD_CYC_DESEL 3'h0
`define PSD_CYC_READ 3'h1
`define PSD_CYC_DUMMY 3'h2
`define PSD_CYC_WRITE 3'h3
`define PSD_CYC_ABORT 3'h4
`define PSD_CYC_STALL 3'h5
`define PSD_CYC_SLEEP 3'h6
`define PSD_BURST_NONE 2'h0
`define PSD_BURST_RD 2'h1
`define PSD_BURST_WR 2'h2
`endif

// ==== rtl/psd_mem.v ====
`timescale 1ns/10ps
`include "psd_defs.vh"
// byte-lane masked storage array, registered read
module psd_mem #(
  parameter ADDR_W = `PSD_ADDR_W,
  parameter LANES = `PSD_LANES,
  parameter LANE_W = `PSD_LANE_W
) (
  input wire clk,
  input wire rd_en,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [LANES*LANE_W-1:0] rd_data,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [LANES-1:0] wr_lane,
  input wire [LANES*LANE_W-1:0] wr_data
);
  reg [LANES*LANE_W-1:0] store [0:(1<<ADDR_W)-1];
  integer i;
  always @(posedge clk) begin
    for (i = 0; i < LANES; i = i + 1) begin
      if (wr_lane[i]) begin
        store[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
      end
      // same-edge write forwarded, the array alone would give stale bytes
      if (rd_en) begin
        if (wr_lane[i] && (wr_addr == rd_addr)) begin
          rd_data[i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
        end else begin
          rd_data[i*LANE_W +: LANE_W] <= store[rd_addr][i*LANE_W +: LANE_W];
        end
      end
    end
  end
endmodule

// ==== rtl/psd_sram.v ====
`timescale 1ns/10ps
`include "psd_defs.vh"
// Notes on behaviour
// - all chip selects active at load, else deselect and tristate bus
// - selected load with write strobe high starts read burst at external address
// - advance during read burst reads next address, ignoring selects and strobe
// - read begun with output enable off is dummy read, bus tristated
// - read continuation with output enable off advances address, bus stays tristated
// - selected load, strobe low, any lane selected starts write burst
// - advance during write burst writes next address, ignoring selects and strobe
// - write load with no lane selected is abort, nothing stored
// - write continuation with no lane selected advances address, stores nothing
// - clock qualify high while awake with no sleep request makes the edge ignored, pipeline and burst state held, cycle type set to stall
// - each byte select gates one byte plus parity independently
// - strobe high means read regardless of byte selects
// - data and parity pins tristated once a write cycle is detected
// - output enable acts combinationally and is masked during writes
// - read data driven only with output enable active and device awake
// - after reset device deselected with pins tristated
// - two-bit burst counter wraps, so every fourth advance returns to the loaded address
// - sleep tristates bus, two cycles to enter or leave
module psd_sram #(
  parameter ADDR_W = `PSD_ADDR_W,
  parameter SLEEP_CYC = `PSD_SLEEP_CYC
) (
  input wire clk,
  input wire rstn,
  input wire [ADDR_W-1:0] addr,
  input wire chip_sel1_n,
  input wire chip_sel2,
  input wire chip_sel3_n,
  input wire advance_or_load,
  input wire write_n,
  input wire [`PSD_LANES-1:0] byte_write_select_n,
  input wire output_enable_n,
  input wire clock_qualify_n,
  input wire sleep_request,
  input wire linear_burst,
  input wire [`PSD_DATA_W-1:0] data_in,
  output wire [`PSD_DATA_W-1:0] data_out,
  output wire [`PSD_LANES-1:0] data_oe,
  output wire [`PSD_LANES-1:0] parity_oe,
  output reg [2:0] cycle_type,
  output wire asleep
);
  localparam ST_AWAKE = 2'h0;
  localparam ST_ENTER = 2'h1;
  localparam ST_SLEEP = 2'h2;
  localparam ST_EXIT = 2'h3;
  // the edge that sees the change counts as the first of the sleep cycles
  localparam integer SLEEP_LAST_I = SLEEP_CYC - 1;
  localparam [1:0] SLEEP_LAST = SLEEP_LAST_I[1:0];

  reg [1:0] sleep_state;
  reg [1:0] sleep_cnt;
  reg [ADDR_W-1:0] base_addr;
  reg [`PSD_BURST_W-1:0] start_cnt;
  reg [`PSD_BURST_W-1:0] beat;
  reg [1:0] burst_kind;
  // two-stage pipeline: stage 1 after command edge, stage 2 at data edge
  reg s1_read;
  reg s1_write;
  reg [ADDR_W-1:0] s1_addr;
  reg [`PSD_LANES-1:0] s1_lane;
  reg s2_read;
  reg s2_write;
  reg [ADDR_W-1:0] s2_addr;
  reg [`PSD_LANES-1:0] s2_lane;
  reg [2:0] next_cycle;
  reg [ADDR_W-1:0] next_addr;
  reg next_read;
  reg next_write;
  reg [`PSD_LANES-1:0] next_lane;
  reg [1:0] next_kind;

  wire selected = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
  wire any_lane = ~&byte_write_select_n;
  wire awake = (sleep_state == ST_AWAKE);
  wire [`PSD_BURST_W-1:0] next_beat = beat + `PSD_ONE_2;
  wire [`PSD_BURST_W-1:0] lin_low = start_cnt + next_beat;
  wire [`PSD_BURST_W-1:0] intl_low = start_cnt ^ next_beat;
  wire [ADDR_W-1:0] burst_addr = {base_addr[ADDR_W-1:`PSD_BURST_W], linear_burst ? lin_low : intl_low};
  wire [`PSD_DATA_W-1:0] mem_q;

  assign asleep = (sleep_state == ST_SLEEP);

  always @* begin
    next_cycle = `PSD_CYC_DESEL;
    next_addr = addr;
    next_read = 1'b0;
    next_write = 1'b0;
    next_lane = ~byte_write_select_n;
    next_kind = `PSD_BURST_NONE;
    if (!awake || sleep_request) begin
      next_cycle = `PSD_CYC_SLEEP;
    end else if (clock_qualify_n) begin
      next_cycle = `PSD_CYC_STALL;
    end else if (!advance_or_load) begin
      if (!selected) begin
        next_cycle = `PSD_CYC_DESEL;
      end else if (write_n) begin
        next_read = 1'b1;
        next_kind = `PSD_BURST_RD;
        next_cycle = output_enable_n ? `PSD_CYC_DUMMY : `PSD_CYC_READ;
      end else if (any_lane) begin
        next_write = 1'b1;
        next_kind = `PSD_BURST_WR;
        next_cycle = `PSD_CYC_WRITE;
      end else begin
        next_cycle = `PSD_CYC_ABORT;
      end
    end else begin
      next_addr = burst_addr;
      next_kind = burst_kind;
      case (burst_kind)
        `PSD_BURST_RD: begin
          next_read = 1'b1;
          next_cycle = output_enable_n ? `PSD_CYC_DUMMY : `PSD_CYC_READ;
        end
        `PSD_BURST_WR: begin
          next_write = any_lane;
          next_cycle = any_lane ? `PSD_CYC_WRITE : `PSD_CYC_ABORT;
        end
        default: begin
          next_cycle = `PSD_CYC_DESEL;
        end
      endcase
    end
  end

  // sleep entry and exit take two cycles
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_state <= ST_AWAKE;
      sleep_cnt <= `PSD_ZERO_2;
    end else begin
      case (sleep_state)
        ST_AWAKE: begin
          if (sleep_request) begin
            sleep_state <= ST_ENTER;
            sleep_cnt <= `PSD_ONE_2;
          end
        end
        ST_ENTER: begin
          if (!sleep_request) begin
            sleep_state <= ST_EXIT;
            sleep_cnt <= `PSD_ONE_2;
          end else if (sleep_cnt >= SLEEP_LAST) begin
            sleep_state <= ST_SLEEP;
          end else begin
            sleep_cnt <= sleep_cnt + `PSD_ONE_2;
          end
        end
        ST_SLEEP: begin
          if (!sleep_request) begin
            sleep_state <= ST_EXIT;
            sleep_cnt <= `PSD_ONE_2;
          end
        end
        ST_EXIT: begin
          if (sleep_request) begin
            sleep_state <= ST_ENTER;
            sleep_cnt <= `PSD_ONE_2;
          end else if (sleep_cnt >= SLEEP_LAST) begin
            sleep_state <= ST_AWAKE;
          end else begin
            sleep_cnt <= sleep_cnt + `PSD_ONE_2;
          end
        end
        default: begin
          sleep_state <= ST_AWAKE;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cycle_type <= `PSD_CYC_DESEL;
      base_addr <= {ADDR_W{1'b0}};
      start_cnt <= `PSD_ZERO_2;
      beat <= `PSD_ZERO_2;
      burst_kind <= `PSD_BURST_NONE;
      s1_read <= 1'b0;
      s1_write <= 1'b0;
      s1_addr <= {ADDR_W{1'b0}};
      s1_lane <= {`PSD_LANES{1'b0}};
      s2_read <= 1'b0;
      s2_write <= 1'b0;
      s2_addr <= {ADDR_W{1'b0}};
      s2_lane <= {`PSD_LANES{1'b0}};
    end else if (next_cycle == `PSD_CYC_SLEEP) begin
      // pending accesses dropped on sleep
      cycle_type <= next_cycle;
      burst_kind <= `PSD_BURST_NONE;
      s1_read <= 1'b0;
      s1_write <= 1'b0;
      s2_read <= 1'b0;
      s2_write <= 1'b0;
    end else if (clock_qualify_n) begin
      cycle_type <= `PSD_CYC_STALL;
    end else begin
      cycle_type <= next_cycle;
      burst_kind <= next_kind;
      if (!advance_or_load) begin
        base_addr <= addr;
        start_cnt <= addr[`PSD_BURST_W-1:0];
        beat <= `PSD_ZERO_2;
      end else if (burst_kind != `PSD_BURST_NONE) begin
        beat <= next_beat;
      end
      s1_read <= next_read;
      s1_write <= next_write;
      s1_addr <= next_addr;
      s1_lane <= next_write ? next_lane : {`PSD_LANES{1'b0}};
      s2_read <= s1_read;
      s2_write <= s1_write;
      s2_addr <= s1_addr;
      s2_lane <= s1_lane;
    end
  end

  // write happens at second edge when data is on the bus
  // stage 2 holds the write while the controller drives its data
  wire do_write = s2_write & ~clock_qualify_n & awake;
  wire do_read = s1_read & ~clock_qualify_n & awake;

  psd_mem #(
    .ADDR_W(ADDR_W),
    .LANES(`PSD_LANES),
    .LANE_W(`PSD_LANE_W)
  ) u_mem (
    .clk(clk),
    .rd_en(do_read),
    .rd_addr(s1_addr),
    .rd_data(mem_q),
    .wr_addr(s2_addr),
    .wr_lane(do_write ? s2_lane : {`PSD_LANES{1'b0}}),
    .wr_data(data_in)
  );

  assign data_out = mem_q;
  wire drive = s2_read & ~s2_write & ~output_enable_n & awake;
  assign data_oe = {`PSD_LANES{drive}};
  assign parity_oe = {`PSD_LANES{drive}};
endmodule

// ==== bench/psd_checker.sv ====
`timescale 1ns/10ps
`include "psd_defs.vh"
module psd_checker #(parameter ADDR_W = 18, parameter SLEEP_CYC = 2) (
  input wire clk,
  input wire rstn,
  input wire chip_sel1_n,
  input wire chip_sel2,
  input wire chip_sel3_n,
  input wire advance_or_load,
  input wire write_n,
  input wire [3:0] byte_write_select_n,
  input wire output_enable_n,
  input wire clock_qualify_n,
  input wire sleep_request,
  input wire [35:0] data_out,
  input wire [3:0] data_oe,
  input wire [3:0] parity_oe,
  input wire [2:0] cycle_type,
  input wire asleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire q = !clock_qualify_n && !sleep_request;
  wire sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
  // previous edge not in sleep means the device is awake at this one
  wire up = cycle_type != `PSD_CYC_SLEEP;
  wire ld = q && up && !advance_or_load;
  sequence rd_cmd; ld && sel && write_n ##1 q; endsequence
  sequence wr_cmd; ld && sel && !write_n ##1 q; endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn ##1 !rstn |-> data_oe == 4'h0 && cycle_type == `PSD_CYC_DESEL) else $error("driven in reset");
  a_lane_pair: assert property (data_oe == parity_oe) else $error("parity enable split");
  a_read_drive: assert property (rd_cmd |=> data_oe == (output_enable_n ? 4'h0 : 4'hf))
    else $error("read drive wrong");
  a_write_hiz: assert property (wr_cmd |=> data_oe == 4'h0) else $error("driven in write");
  a_oe_async: assert property (output_enable_n |-> data_oe == 4'h0) else $error("driven with oe off");
  a_desel_hiz: assert property (ld && !sel ##1 q |=> data_oe == 4'h0) else $error("driven deselected");
  a_stall_hold: assert property (clock_qualify_n && !sleep_request && up
    |=> $stable(data_out) && cycle_type == `PSD_CYC_STALL) else $error("stall not held");
  a_abort_type: assert property (ld && sel && !write_n && byte_write_select_n == 4'hf
    |=> cycle_type == `PSD_CYC_ABORT) else $error("abort not decoded");
  a_sleep_enter: assert property ($rose(sleep_request) |-> ##2 asleep) else $error("no sleep");
  a_sleep_exit: assert property (!sleep_request [*4] |-> !asleep) else $error("still asleep");
endmodule
bind psd_sram psd_checker #(.ADDR_W(ADDR_W), .SLEEP_CYC(SLEEP_CYC)) chk (.*);

// ==== bench/psd_ctl_model.sv ====
`timescale 1ns/10ps
module psd_ctl_model (
  input wire clk,
  input wire clock_qualify_n,
  input wire wr_go,
  input wire [35:0] wr_data,
  output reg [35:0] bus_d
);
  reg s1 = 0, s2 = 0;
  reg [35:0] d1 = 36'h0, d2 = 36'h0;
  initial bus_d = 36'h0;
  always @(posedge clk) begin
    if (!clock_qualify_n) begin
      s1 <= wr_go;
      d1 <= wr_data;
      s2 <= s1;
      d2 <= d1;
    end
  end
  // released bus toggles so a stale value never looks valid
  always @(negedge clk) bus_d <= s2 ? d2 : ~bus_d;
endmodule

// ==== bench/psd_sram_tb.sv ====
`timescale 1ns/10ps
`include "psd_defs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
module psd_sram_tb;
  reg clk = 0, rstn = 0, chip_sel1_n = 1, chip_sel2 = 0, chip_sel3_n = 1, advance_or_load = 0, write_n = 1;
  reg output_enable_n = 0, clock_qualify_n = 0, sleep_request = 0, linear_burst = 1, go = 0;
  reg [3:0] byte_write_select_n = 4'hf;
  reg [17:0] addr = 18'h0;
  reg [35:0] wd = 36'h0;
  wire [35:0] data_out, ctl_d, data_in;
  wire [3:0] data_oe, parity_oe;
  wire [2:0] cycle_type;
  wire asleep;
  wire [35:0] m = {{9{data_oe[3]}}, {9{data_oe[2]}}, {9{data_oe[1]}}, {9{data_oe[0]}}};
  integer failures = 0, comparisons = 0, cycles = 0, k;
  reg [35:0] got[$];
  assign data_in = (data_out & m) | (ctl_d & ~m);
  psd_sram dut (.*);
  psd_ctl_model ctl (.clk(clk), .clock_qualify_n(clock_qualify_n), .wr_go(go), .wr_data(wd), .bus_d(ctl_d));
  always #4 clk = ~clk;
  // only qualified edges count, so stalled repeats are not collected twice
  always @(posedge clk) begin
    cycles++;
    if (rstn && !clock_qualify_n && data_oe == 4'hf) got.push_back(data_out);
    if (cycles == 2000) begin
      failures++;
      wrap_up;
    end
  end
  function [35:0] dv(input integer i);
    dv = 36'h9a5c3e170 + i * 36'h111111111;
  endfunction
  task op(input [2:0] cs, input al, input w, input [3:0] bw, input [17:0] a, input [35:0] d);
    @(negedge clk);
    {chip_sel3_n, chip_sel2, chip_sel1_n} = cs;
    advance_or_load = al;
    write_n = w;
    byte_write_select_n = bw;
    addr = a;
    wd = d;
    go = !w;
    clock_qualify_n = 0;
  endtask
  task rd(input [17:0] a);
    op(3'h2, 0, 1, 4'hf, a, 36'h0);
  endtask
  task wr(input [17:0] a, input [3:0] bw, input [35:0] d);
    op(3'h2, 0, 0, bw, a, d);
  endtask
  task idle(input integer n);
    repeat (n) op(3'h3, 0, 1, 4'hf, 18'h0, 36'h0);
  endtask
  task t_burst(input l, input [7:0] ord);
    got.delete();
    linear_burst = l;
    wr(18'h101, 4'h0, dv(0));
    for (k = 1; k < 4; k++) op(3'h0, 1, 0, 4'h0, 18'h0, dv(k));
    for (k = 0; k < 4; k++) rd({16'h40, ord[2*k +: 2]});
    rd(18'h101);
    for (k = 1; k < 4; k++) op(3'h0, 1, 1, 4'hf, 18'h0, 36'h0);
    // last beats still on the bus for two more edges
    idle(3);
    output_enable_n = 1;
    rd(18'h101);
    for (k = 1; k < 4; k++) op(3'h0, 1, 1, 4'hf, 18'h0, 36'h0);
    idle(3);
    output_enable_n = 0;
    `CHK("burst count", 8, got.size())
    for (k = 0; k < 8; k++) `CHK("burst data", dv(k % 4), got[k])
    $display("t_burst done");
  endtask
  task t_lanes;
    got.delete();
    wr(18'h20, 4'h0, 36'h0);
    wr(18'h20, 4'h5, 36'hfffffffff);
    wr(18'h20, 4'hf, 36'h123456789);
    op(3'h0, 0, 0, 4'h0, 18'h20, 36'h0);
    op(3'h3, 0, 0, 4'h0, 18'h20, 36'h0);
    op(3'h6, 0, 0, 4'h0, 18'h20, 36'h0);
    output_enable_n = 1;
    rd(18'h20);
    idle(3);
    output_enable_n = 0;
    op(3'h0, 0, 1, 4'hf, 18'h20, 36'h0);
    op(3'h2, 0, 1, 4'h0, 18'h20, 36'h0);
    idle(3);
    `CHK("lane count", 1, got.size())
    `CHK("lane data", 36'hff803fe00, got[0])
    $display("t_lanes done");
  endtask
  task t_stall;
    got.delete();
    rd(18'h20);
    wr(18'h24, 4'h0, dv(5));
    // stall lands between write command and its data
    @(negedge clk);
    clock_qualify_n = 1;
    repeat (2) @(negedge clk);
    idle(3);
    rd(18'h24);
    idle(3);
    `CHK("stall count", 2, got.size())
    `CHK("stall data", 36'hff803fe00, got[0])
    `CHK("after stall", dv(5), got[1])
    $display("t_stall done");
  endtask
  task t_sleep;
    got.delete();
    sleep_request = 1;
    idle(4);
    `CHK("asleep", 1'b1, asleep)
    `CHK("sleep oe", 4'h0, data_oe)
    sleep_request = 0;
    idle(4);
    `CHK("awake", 1'b0, asleep)
    rd(18'h20);
    idle(3);
    `CHK("wake data", 36'hff803fe00, got[0])
    $display("t_sleep done");
  endtask
  task wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    `CHK("reset oe", 4'h0, data_oe)
    `CHK("reset cycle", `PSD_CYC_DESEL, cycle_type)
    @(negedge clk);
    rstn = 1;
    idle(1);
    t_burst(1, 8'b00_11_10_01);
    t_burst(0, 8'b10_11_00_01);
    t_lanes;
    t_stall;
    t_sleep;
    wrap_up;
  end
endmodule
